//--- bench/pueh_checker_properties.sv
`timescale 1ns/10ps
`include "pueh_consts.vh"
// Response causes and timing at the block's ports
module pueh_checker (
  input wire        clk_in,
  input wire        rst_b_in,
  input wire        perr_rd_cpl_in,
  input wire        cpl_poisoned_in,
  input wire        addr_par_err_in,
  input wire        attr_par_err_in,
  input wire        wr_data_err_in,
  input wire        ur_cpl_in,
  input wire        ca_cpl_in,
  input wire        cpl_timeout_in,
  input wire        req_is_read_in,
  input wire        disc_timeout_in,
  input wire        target_abort_out,
  input wire        normal_term_out,
  input wire        all_ones_out,
  input wire [31:0] rd_fill_out,
  input wire        perr_drive_out,
  input wire        forward_rest_out,
  input wire        msg_valid_out
);
  default clocking dcb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Events able to raise a message
  wire msg_src = (perr_rd_cpl_in && !cpl_poisoned_in) || addr_par_err_in ||
    attr_par_err_in || wr_data_err_in || cpl_timeout_in || disc_timeout_in;
  // Events able to end in Target-Abort
  wire abort_src = addr_par_err_in || attr_par_err_in || ur_cpl_in ||
    ca_cpl_in || cpl_timeout_in;
  // Completions handled as Unsupported Request
  sequence ur_like_s;
    (ur_cpl_in || cpl_timeout_in) && !ca_cpl_in;
  endsequence
  // Poisoned completion report, nothing else pending
  sequence poisoned_s;
    perr_rd_cpl_in && cpl_poisoned_in && !msg_src;
  endsequence
  forward_rest_a:
    assert property (perr_rd_cpl_in |=> forward_rest_out)
    else $error("completion not forwarded on");
  poison_quiet_a:
    assert property (poisoned_s |=> !msg_valid_out)
    else $error("message for poisoned completion");
  msg_cause_a:
    assert property (msg_valid_out |-> $past(msg_src))
    else $error("message without a cause");
  abort_cause_a:
    assert property (target_abort_out |-> $past(abort_src))
    else $error("abort without a cause");
  ca_abort_a:
    assert property (ca_cpl_in |=> target_abort_out ##1 !target_abort_out)
    else $error("completer abort not one abort pulse");
  fill_ones_a:
    assert property (all_ones_out |->
      normal_term_out && rd_fill_out == `PUEH_ALL_ONES)
    else $error("all-ones fill wrong");
  ones_cause_a:
    assert property (all_ones_out |->
      $past(req_is_read_in && (ur_cpl_in || cpl_timeout_in)))
    else $error("all-ones without a read fallback");
  ur_one_way_a:
    assert property (ur_like_s |=> normal_term_out != target_abort_out)
    else $error("fallback ended neither or both ways");
  perr_cause_a:
    assert property (perr_drive_out |-> $past(wr_data_err_in))
    else $error("parity driven without write data error");
endmodule // pueh_checker
bind pueh_error_handler pueh_checker chk_u (.clk_in, .rst_b_in,
  .perr_rd_cpl_in, .cpl_poisoned_in, .addr_par_err_in, .attr_par_err_in,
  .wr_data_err_in, .ur_cpl_in, .ca_cpl_in, .cpl_timeout_in, .req_is_read_in,
  .disc_timeout_in, .target_abort_out, .normal_term_out, .all_ones_out,
  .rd_fill_out, .perr_drive_out, .forward_rest_out, .msg_valid_out);

//--- bench/pueh_far_model.sv
`timescale 1ns/10ps
// Far side: PCI master and PCIe completer, one event per launch
module pueh_far_model (
  input  wire       clk_in,             // Core clock
  input  wire       rst_b_in,           // Async reset, active low
  input  wire       go_in,              // Launch an event next cycle
  input  wire [3:0] kind_in,            // Event kind, 0 to 10
  output reg  [7:0] ev_out = 8'h00,     // One-hot event pulse
  output reg        pois_out = 1'b0,    // Completion was poisoned
  output reg        rd_out = 1'b0       // Owning request is a read
);
  // Pulse position for each kind
  wire [2:0] idx = (kind_in < 4'h2) ? 3'h0 :
    (kind_in < 4'h5) ? kind_in[2:0] - 3'h1 :
    (kind_in < 4'h7) ? 3'h4 : (kind_in == 4'h7) ? 3'h5 :
    (kind_in < 4'ha) ? 3'h6 : 3'h7;
  // Qualifiers toggle when idle so stale values never help
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ev_out   <= 8'h00;
      pois_out <= 1'b0;
      rd_out   <= 1'b0;
    end else if (go_in) begin
      ev_out   <= 8'h01 << idx;
      pois_out <= (kind_in == 4'h1);
      rd_out   <= (kind_in == 4'h5) || (kind_in == 4'h8);
    end else begin
      ev_out   <= 8'h00;
      pois_out <= ~pois_out;
      rd_out   <= ~rd_out;
    end
  end
endmodule // pueh_far_model

//--- bench/test_pueh_error_handler.sv
`timescale 1ns/10ps
`include "pueh_consts.vh"
module test_pueh_error_handler;
  logic        clk_in = 1'b0;     // 5 ns clock
  logic        rst_b_in = 1'b0;   // Reset, active low
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0000_0000;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [31:0] reg_rdata_out, rd_fill_out;
  logic [31:0] err_hdr_in = 32'h0000_0000;
  logic        go = 1'b0;         // Launch far-side event
  logic [3:0]  kind = 4'h0;       // Far-side event kind
  logic [7:0]  ev;                // Far-side event pulses
  logic perr_rd_cpl_in, cpl_poisoned_in, addr_par_err_in, attr_par_err_in;
  logic wr_data_err_in, ur_cpl_in, ca_cpl_in, cpl_timeout_in;
  logic req_is_read_in, disc_timeout_in, target_abort_out, normal_term_out;
  logic all_ones_out, discard_out, forward_rest_out, perr_drive_out;
  logic msg_valid_out, msg_fatal_out;
  logic [5:0]  ctl;               // Control as written
  logic [4:0]  msk, sev, es;      // Mask, severity, expected status
  logic [1:0]  pcf;               // Timeout mask and severity
  logic [7:0]  eo, om, eb, bm;    // Expected values and check masks
  logic [2:0]  ptr_e;             // Expected log pointer
  logic        lg;                // Header log expected
  int err_total = 0, samples_checked = 0, cycles = 0;
  assign {disc_timeout_in, cpl_timeout_in, ca_cpl_in, ur_cpl_in,
    wr_data_err_in, attr_par_err_in, addr_par_err_in, perr_rd_cpl_in} = ev;
  pueh_error_handler dut (.clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .perr_rd_cpl_in, .cpl_poisoned_in,
    .addr_par_err_in, .attr_par_err_in, .wr_data_err_in, .err_hdr_in,
    .ur_cpl_in, .ca_cpl_in, .cpl_timeout_in, .req_is_read_in,
    .disc_timeout_in, .target_abort_out, .normal_term_out, .all_ones_out,
    .rd_fill_out, .discard_out, .forward_rest_out, .perr_drive_out,
    .msg_valid_out, .msg_fatal_out);
  pueh_far_model far (.clk_in, .rst_b_in, .go_in(go), .kind_in(kind),
    .ev_out(ev), .pois_out(cpl_poisoned_in), .rd_out(req_is_read_in));
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  // Hang guard, far above the expected run
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read; data stand only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    @(posedge clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 chk(reg_rdata_out & m, e & m);
  endtask
  task automatic setup_regs();
    wr(`PUEH_OFS_CTRL, {26'h0, ctl});
    wr(`PUEH_OFS_SEC_MASK, {27'h0, msk});
    wr(`PUEH_OFS_SEC_SEV, {27'h0, sev});
    wr(`PUEH_OFS_PRI_CFG, {30'h0, pcf});
  endtask
  task automatic clear_all();
    wr(`PUEH_OFS_SEC_STATUS, `PUEH_ALL_ONES);
    wr(`PUEH_OFS_PRI_STATUS, `PUEH_ALL_ONES);
    wr(`PUEH_OFS_BUS_STATUS, `PUEH_ALL_ONES);
  endtask
  // Event pulse lands one cycle after launch; outputs a cycle later
  task automatic fire(input logic [3:0] k);
    @(posedge clk_in);
    go <= 1'b1;
    kind <= k;
    err_hdr_in <= $urandom;
    @(posedge clk_in);
    go <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  // Expected responses; an abort never discards on its own
  task automatic exp_for(input logic [3:0] k);
    logic pe, ma, ur, rdk, sv, mv, ta, nt, completion_timeout_status;
    pe = ctl[`PUEH_CTRL_PERESP];
    ma = ctl[`PUEH_CTRL_MA_MODE];
    completion_timeout_status = k == 4'h8 || k == 4'h9;
    ur = completion_timeout_status || k == 4'h5 || k == 4'h6;
    rdk = k == 4'h5 || k == 4'h8;
    ptr_e = k < 2 ? 3'h0 : k < 5 ? k[2:0] - 3'h1 : k == 10 ? 3'h4 : 3'h7;
    es = (ptr_e == 3'h7 || (ptr_e inside {1, 2} && !pe)) ? 5'h00
      : 5'h01 << ptr_e;
    sv = completion_timeout_status ? pcf[`PUEH_PRI_CTO_SEV] : ptr_e < 5 ? sev[ptr_e] : 1'b0;
    mv = completion_timeout_status ? !pcf[`PUEH_PRI_CTO_MASK]
      : ptr_e == 4 ? !msk[4] || ctl[`PUEH_CTRL_DISC_SERR]
      : es != 0 && !msk[ptr_e] && k != 1;
    mv = mv && (ctl[`PUEH_CTRL_SYSTEM_ERROR_ENABLE] ||
      (sv ? ctl[`PUEH_CTRL_FATAL_EN] : ctl[`PUEH_CTRL_NFATAL_EN]));
    ta = (ptr_e inside {1, 2} && pe) || (ur && ma) || k == 7;
    nt = ur && !ma;
    eo = {sv && mv, mv, k == 4 && pe, k < 2,
      (ptr_e inside {1, 2, 3} && pe) || (nt && !rdk), nt && rdk, nt, ta};
    om = 8'hff;
    eb = {es[3:0] != 0 && !sv, es[3:0] != 0 && sv, k == 7, ta && k != 7,
      ptr_e inside {1, 2, 3}, k == 7, ur, mv && ctl[`PUEH_CTRL_SYSTEM_ERROR_ENABLE]};
    bm = (ptr_e inside {1, 2} && !pe) ? 8'h3f : k == 7 ? 8'hef : 8'hff;
    lg = es[3:0] != 0 && !msk[ptr_e];
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    logic [3:0]  k;
    logic [31:0] h;
    logic [7:0]  o;
    void'($urandom(32'h8d65_a549));
    repeat (8) @(posedge clk_in);
    rst_b_in <= 1'b1;
    // Reset values; an unmapped write must leave no trace
    wr(8'h24, `PUEH_ALL_ONES);
    for (int a = 0; a < 40; a += 4) begin
      if (a != 28) rc(8'(a), `PUEH_ALL_ONES, 32'h0000_0000);
    end
    // First logged error holds the pointer until its bit is cleared
    {ctl, msk, sev, pcf} = 18'h0f000;
    setup_regs();
    fire(4'h4);
    h = err_hdr_in;
    fire(4'h0);
    rc(`PUEH_OFS_ERR_CAP, `PUEH_ALL_ONES, 32'h8000_0003);
    rc(`PUEH_OFS_HDR_LOG, `PUEH_ALL_ONES, h);
    wr(`PUEH_OFS_SEC_STATUS, 32'h0000_0001);
    rc(`PUEH_OFS_ERR_CAP, `PUEH_ALL_ONES, 32'h8000_0003);
    wr(`PUEH_OFS_SEC_STATUS, 32'h0000_0008);
    rc(`PUEH_OFS_ERR_CAP, 32'h8000_0000, 32'h0000_0000);
    clear_all();
    // Random settings against every event kind
    repeat (150) begin
      {ctl, msk, sev, pcf} = 18'($urandom);
      k = 4'($urandom_range(10));
      setup_regs();
      exp_for(k);
      fire(k);
      o = {msg_fatal_out, msg_valid_out, perr_drive_out, forward_rest_out,
        discard_out, all_ones_out, normal_term_out, target_abort_out};
      chk({28'h0, o[3:0] & om[3:0]}, {28'h0, eo[3:0] & om[3:0]});
      chk({28'h0, o[7:4]}, {28'h0, eo[7:4]});
      chk(rd_fill_out, eo[2] ? `PUEH_ALL_ONES : 32'h0000_0000);
      rc(`PUEH_OFS_SEC_STATUS, 32'h0000_001f, {27'h0, es});
      rc(`PUEH_OFS_PRI_STATUS, 32'h0000_0001,
        {31'h0, k == 4'h8 || k == 4'h9});
      rc(`PUEH_OFS_BUS_STATUS, {24'h0, bm}, {24'h0, eb});
      rc(`PUEH_OFS_ERR_CAP, lg ? 32'h8000_0007 : 32'h8000_0000,
        {lg, 28'h0, ptr_e});
      if (lg) rc(`PUEH_OFS_HDR_LOG, `PUEH_ALL_ONES, err_hdr_in);
      clear_all();
    end
    complete_run();
  end
endmodule // test_pueh_error_handler

//--- hw/pueh_consts.vh
`ifndef PUEH_CONSTS_VH
`define PUEH_CONSTS_VH

// Register word addresses (byte offsets, one word each)
`define PUEH_OFS_CTRL        8'h00
`define PUEH_OFS_SEC_STATUS  8'h04
`define PUEH_OFS_SEC_MASK    8'h08
`define PUEH_OFS_SEC_SEV     8'h0C
`define PUEH_OFS_PRI_STATUS  8'h10
`define PUEH_OFS_PRI_CFG     8'h14
`define PUEH_OFS_ERR_CAP     8'h18
`define PUEH_OFS_HDR_LOG     8'h1C
`define PUEH_OFS_BUS_STATUS  8'h20

// Control register field positions
`define PUEH_CTRL_SYSTEM_ERROR_ENABLE    0
`define PUEH_CTRL_FATAL_EN   1
`define PUEH_CTRL_NFATAL_EN  2
`define PUEH_CTRL_PERESP     3
`define PUEH_CTRL_MA_MODE    4
`define PUEH_CTRL_DISC_SERR  5
`define PUEH_CTRL_W          6

// Secondary uncorrectable error bits (status, mask, severity)
`define PUEH_SEC_PERR_RPT    0
`define PUEH_SEC_ADDR_PAR    1
`define PUEH_SEC_ATTR_PAR    2
`define PUEH_SEC_DATA_ERR    3
`define PUEH_SEC_DISC_TO     4
`define PUEH_SEC_W           5

// Primary uncorrectable config bits
`define PUEH_PRI_CTO_MASK    0
`define PUEH_PRI_CTO_SEV     1

// Bus and device status bits
`define PUEH_BUS_SIG_SERR    0
`define PUEH_BUS_RX_MA       1
`define PUEH_BUS_RX_TA       2
`define PUEH_BUS_SEC_DPE     3
`define PUEH_BUS_SEC_STA     4
`define PUEH_BUS_SEC_RTA     5
`define PUEH_BUS_FATAL_DET   6
`define PUEH_BUS_NFATAL_DET  7
`define PUEH_BUS_W           8

// Error capability register layout
`define PUEH_CAP_VALID_BIT   31
`define PUEH_PTR_W           3

// Reset values
`define PUEH_RST_CTRL        6'h00
`define PUEH_RST_SEC_MASK    5'h00
`define PUEH_RST_SEC_SEV     5'h00
`define PUEH_RST_PRI_CFG     2'h0
`define PUEH_ALL_ONES        32'hFFFF_FFFF

`endif

//--- hw/pueh_error_handler.v
// What this block does
// - PERR on clean read completion: continue, flag
// - Log header, pointer if unmasked and free
// - Send message by severity when unmasked, enabled
// - Message with system-error enable sets signalled flag
// - Set fatal or nonfatal detected per error
// - Poisoned completion PERR: same, but no message
// - Address parity: target abort, discard, status
// - Attribute parity: target abort, discard, status
// - Detected parity error set regardless of enable
// - Parity termination sets signalled target abort
// - UR with abort mode: target abort, flag
// - UR read, mode clear: all ones, normal
// - UR write, mode clear: normal end, discard
// - Every UR sets received master abort
// - Completer abort sets secondary received target abort
// - Completer abort: pass earlier data, then abort
// - Abort from completer abort sets primary flag
// - Completion timeout behaves like UR completion
// - Timeout sets status, message by severity
// - Discard timeout message if unmasked or forced
// - Write data error with enable: discard, PERR
`timescale 1ns/10ps
`include "pueh_consts.vh"

module pueh_error_handler (
  input  wire        clk_in,            // 200 MHz core clock
  input  wire        rst_b_in,          // Async reset, active low
  // Register port
  input  wire [7:0]  reg_addr_in,       // Byte address
  input  wire [31:0] reg_wdata_in,      // Write data
  input  wire        reg_wr_in,         // Write strobe
  input  wire        reg_rd_in,         // Read strobe
  output reg  [31:0] reg_rdata_out,     // Read data, cycle after strobe
  // Error events from the secondary side, one-cycle pulses
  input  wire        perr_rd_cpl_in,    // Master PERR during read cpl
  input  wire        cpl_poisoned_in,   // That completion was poisoned
  input  wire        addr_par_err_in,   // Address phase parity error
  input  wire        attr_par_err_in,   // Attribute phase parity error
  input  wire        wr_data_err_in,    // Non-posted write data error
  input  wire [31:0] err_hdr_in,        // Header of offending request
  // Completion events from the upstream link, one-cycle pulses
  input  wire        ur_cpl_in,         // Unsupported Request status
  input  wire        ca_cpl_in,         // Completer Abort status
  input  wire        cpl_timeout_in,    // Completion timeout
  input  wire        req_is_read_in,    // Owning request is a read
  input  wire        disc_timeout_in,   // Delayed discard timeout
  // Responses toward the PCI master, one-cycle pulses
  output reg         target_abort_out,  // Terminate with Target-Abort
  output reg         normal_term_out,   // Terminate normally (TRDY)
  output reg         all_ones_out,      // Return all-ones read data
  output reg  [31:0] rd_fill_out,       // Fill data for all-ones case
  output reg         discard_out,       // Drop the transaction
  output reg         forward_rest_out,  // Keep forwarding completion
  output reg         perr_drive_out,    // Assert PERR on the bus
  // Error message toward the upstream link
  output reg         msg_valid_out,     // Send one error message
  output reg         msg_fatal_out      // 1 fatal, 0 non-fatal
);

  // Write-one-to-clear update where a new event wins over the clear
  function [31:0] w1c;
    input [31:0] cur;
    input [31:0] clr;
    input [31:0] set;
    begin
      w1c = (cur & ~clr) | set;
    end
  endfunction

  // Lowest set bit index, for the first error pointer
  function [`PUEH_PTR_W-1:0] first_idx;
    input [`PUEH_SEC_W-1:0] v;
    integer i;
    begin
      first_idx = {`PUEH_PTR_W{1'b0}};
      for (i = `PUEH_SEC_W-1; i >= 0; i = i - 1) begin
        if (v[i]) begin
          first_idx = i[`PUEH_PTR_W-1:0];
        end
      end
    end
  endfunction

  // Software-visible registers
  reg [`PUEH_CTRL_W-1:0]   ctrl_r;       // Enables and modes
  reg [`PUEH_SEC_W-1:0]    sec_stat_r;   // Secondary error status
  reg [`PUEH_SEC_W-1:0]    sec_mask_r;   // Secondary error mask
  reg [`PUEH_SEC_W-1:0]    sec_sev_r;    // Secondary severity, 1 fatal
  reg                      cto_stat_r;   // Completion timeout status
  reg [1:0]                pri_cfg_r;    // Timeout mask and severity
  reg                      ptr_valid_r;  // First error pointer valid
  reg [`PUEH_PTR_W-1:0]    ptr_r;        // First error pointer
  reg [31:0]               hdr_r;        // Header log
  reg [`PUEH_BUS_W-1:0]    bus_stat_r;   // Bus and device status

  // Named control bits
  wire system_error_enable              = ctrl_r[`PUEH_CTRL_SYSTEM_ERROR_ENABLE];
  wire fatal_report_enable              = ctrl_r[`PUEH_CTRL_FATAL_EN];
  wire nonfatal_report_enable           = ctrl_r[`PUEH_CTRL_NFATAL_EN];
  wire secondary_parity_response_enable = ctrl_r[`PUEH_CTRL_PERESP];
  wire master_abort_mode                = ctrl_r[`PUEH_CTRL_MA_MODE];
  wire discard_timeout_serr_enable      = ctrl_r[`PUEH_CTRL_DISC_SERR];

  // Decoded register writes
  wire wr_ctrl = reg_wr_in && (reg_addr_in == `PUEH_OFS_CTRL);
  wire wr_sst  = reg_wr_in && (reg_addr_in == `PUEH_OFS_SEC_STATUS);
  wire wr_smsk = reg_wr_in && (reg_addr_in == `PUEH_OFS_SEC_MASK);
  wire wr_ssev = reg_wr_in && (reg_addr_in == `PUEH_OFS_SEC_SEV);
  wire wr_pst  = reg_wr_in && (reg_addr_in == `PUEH_OFS_PRI_STATUS);
  wire wr_pcfg = reg_wr_in && (reg_addr_in == `PUEH_OFS_PRI_CFG);
  wire wr_bst  = reg_wr_in && (reg_addr_in == `PUEH_OFS_BUS_STATUS);

  // Clear masks from software writes of ones
  wire [`PUEH_SEC_W-1:0] sec_clr =
    wr_sst ? reg_wdata_in[`PUEH_SEC_W-1:0] : {`PUEH_SEC_W{1'b0}};
  wire [`PUEH_BUS_W-1:0] bus_clr =
    wr_bst ? reg_wdata_in[`PUEH_BUS_W-1:0] : {`PUEH_BUS_W{1'b0}};
  wire cto_clr = wr_pst & reg_wdata_in[0];

  // Completion status handling; a timeout is treated as UR
  wire ur_like = ur_cpl_in | cpl_timeout_in;
  wire ur_ta   = ur_like & master_abort_mode;
  wire ur_norm = ur_like & ~master_abort_mode;

  // Parity errors that end in Target-Abort only when enabled
  wire addr_ta = addr_par_err_in & secondary_parity_response_enable;
  wire attr_ta = attr_par_err_in & secondary_parity_response_enable;

  // Secondary error events this cycle
  reg  [`PUEH_SEC_W-1:0] sec_ev;
  always @* begin
    sec_ev = {`PUEH_SEC_W{1'b0}};
    sec_ev[`PUEH_SEC_PERR_RPT] = perr_rd_cpl_in;
    sec_ev[`PUEH_SEC_ADDR_PAR] = addr_ta;
    sec_ev[`PUEH_SEC_ATTR_PAR] = attr_ta;
    sec_ev[`PUEH_SEC_DATA_ERR] = wr_data_err_in;
    sec_ev[`PUEH_SEC_DISC_TO]  = disc_timeout_in;
  end

  // Unmasked events; discard timeout may be forced past its mask
  reg  [`PUEH_SEC_W-1:0] sec_unm;
  always @* begin
    sec_unm = sec_ev & ~sec_mask_r;
    sec_unm[`PUEH_SEC_DISC_TO] = disc_timeout_in &
      (~sec_mask_r[`PUEH_SEC_DISC_TO] | discard_timeout_serr_enable);
  end

  // Reporting allowed for a given severity
  wire rpt_fatal  = system_error_enable | fatal_report_enable;
  wire rpt_nfatal = system_error_enable | nonfatal_report_enable;

  // Which unmasked events may raise a message
  reg  [`PUEH_SEC_W-1:0] sec_msg;
  always @* begin
    sec_msg = sec_unm;
    // Poisoned completion: no message for the reported PERR
    if (cpl_poisoned_in) begin
      sec_msg[`PUEH_SEC_PERR_RPT] = 1'b0;
    end
  end

  // Message requests split by severity
  wire sec_fat = |(sec_msg & sec_sev_r) & rpt_fatal;
  wire sec_nft = |(sec_msg & ~sec_sev_r) & rpt_nfatal;
  wire cto_unm = cpl_timeout_in & ~pri_cfg_r[`PUEH_PRI_CTO_MASK];
  wire cto_fat = cto_unm & pri_cfg_r[`PUEH_PRI_CTO_SEV] & rpt_fatal;
  wire cto_nft = cto_unm & ~pri_cfg_r[`PUEH_PRI_CTO_SEV] & rpt_nfatal;
  wire msg_fat = sec_fat | cto_fat;
  wire msg_nft = sec_nft | cto_nft;
  wire msg_any = msg_fat | msg_nft;

  // Handled errors for detected bits; discard timeout excluded
  wire [`PUEH_SEC_W-1:0] handled =
    sec_ev & ~({{(`PUEH_SEC_W-1){1'b0}}, 1'b1} << `PUEH_SEC_DISC_TO);
  wire det_fat = |(handled & sec_sev_r);
  wire det_nft = |(handled & ~sec_sev_r);

  // Header capture candidates; discard timeout never logs
  wire [`PUEH_SEC_W-1:0] log_cand = sec_unm & handled;
  wire                   log_now  = (|log_cand) & ~ptr_valid_r;

  // Pointer released when software clears the bit it names
  wire ptr_rel = ptr_valid_r & sec_clr[ptr_r];

  // Bus and device status set terms
  reg  [`PUEH_BUS_W-1:0] bus_set;
  always @* begin
    bus_set = {`PUEH_BUS_W{1'b0}};
    bus_set[`PUEH_BUS_SIG_SERR] = msg_any & system_error_enable;
    bus_set[`PUEH_BUS_RX_MA]    = ur_like;
    bus_set[`PUEH_BUS_RX_TA]    = ca_cpl_in;
    bus_set[`PUEH_BUS_SEC_DPE]  = addr_par_err_in | attr_par_err_in
                                  | wr_data_err_in;
    bus_set[`PUEH_BUS_SEC_STA]  = addr_ta | attr_ta | ur_ta;
    bus_set[`PUEH_BUS_SEC_RTA]  = ca_cpl_in;
    bus_set[`PUEH_BUS_FATAL_DET]  = det_fat;
    bus_set[`PUEH_BUS_NFATAL_DET] = det_nft;
  end

  // Control and configuration registers
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_r     <= `PUEH_RST_CTRL;
      sec_mask_r <= `PUEH_RST_SEC_MASK;
      sec_sev_r  <= `PUEH_RST_SEC_SEV;
      pri_cfg_r  <= `PUEH_RST_PRI_CFG;
    end else begin
      // Plain read-write fields
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata_in[`PUEH_CTRL_W-1:0];
      end
      if (wr_smsk) begin
        sec_mask_r <= reg_wdata_in[`PUEH_SEC_W-1:0];
      end
      if (wr_ssev) begin
        sec_sev_r <= reg_wdata_in[`PUEH_SEC_W-1:0];
      end
      if (wr_pcfg) begin
        pri_cfg_r <= reg_wdata_in[1:0];
      end
    end
  end

  // Full-width status updates, cut back to the register widths below
  wire [31:0] sec_stat_w = w1c({27'h000_0000, sec_stat_r},
                               {27'h000_0000, sec_clr},
                               {27'h000_0000, sec_ev});
  wire [31:0] bus_stat_w = w1c({24'h00_0000, bus_stat_r},
                               {24'h00_0000, bus_clr},
                               {24'h00_0000, bus_set});

  // Sticky status; an event in the clear cycle survives
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sec_stat_r <= {`PUEH_SEC_W{1'b0}};
      bus_stat_r <= {`PUEH_BUS_W{1'b0}};
      cto_stat_r <= 1'b0;
    end else begin
      sec_stat_r <= sec_stat_w[`PUEH_SEC_W-1:0];
      bus_stat_r <= bus_stat_w[`PUEH_BUS_W-1:0];
      cto_stat_r <= (cto_stat_r & ~cto_clr) | cpl_timeout_in;
    end
  end

  // First error pointer and header log
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ptr_valid_r <= 1'b0;
      ptr_r       <= {`PUEH_PTR_W{1'b0}};
      hdr_r       <= 32'h0000_0000;
    end else if (log_now) begin
      // Only the first unmasked error is captured
      ptr_valid_r <= 1'b1;
      ptr_r       <= first_idx(log_cand);
      hdr_r       <= err_hdr_in;
    end else if (ptr_rel) begin
      // Header stays for inspection; only validity drops
      ptr_valid_r <= 1'b0;
    end
  end

  // Responses to the PCI master and the upstream link
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      target_abort_out <= 1'b0;
      normal_term_out  <= 1'b0;
      all_ones_out     <= 1'b0;
      rd_fill_out      <= 32'h0000_0000;
      discard_out      <= 1'b0;
      forward_rest_out <= 1'b0;
      perr_drive_out   <= 1'b0;
      msg_valid_out    <= 1'b0;
      msg_fatal_out    <= 1'b0;
    end else begin
      // Completer abort arrives after earlier data went out
      target_abort_out <= addr_ta | attr_ta | ur_ta
                          | ca_cpl_in;
      normal_term_out  <= ur_norm;
      all_ones_out     <= ur_norm & req_is_read_in;
      rd_fill_out      <= (ur_norm & req_is_read_in) ?
                          `PUEH_ALL_ONES : 32'h0000_0000;
      discard_out      <= addr_ta | attr_ta
                          | (ur_norm & ~req_is_read_in)
                          | (wr_data_err_in
                             & secondary_parity_response_enable);
      forward_rest_out <= perr_rd_cpl_in;
      perr_drive_out   <= wr_data_err_in
                          & secondary_parity_response_enable;
      // One message per cycle; fatal wins over non-fatal
      msg_valid_out    <= msg_any;
      msg_fatal_out    <= msg_fat;
    end
  end

  // Read mux; unmapped addresses read zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (reg_addr_in)
      `PUEH_OFS_CTRL:       rd_mux[`PUEH_CTRL_W-1:0] = ctrl_r;
      `PUEH_OFS_SEC_STATUS: rd_mux[`PUEH_SEC_W-1:0]  = sec_stat_r;
      `PUEH_OFS_SEC_MASK:   rd_mux[`PUEH_SEC_W-1:0]  = sec_mask_r;
      `PUEH_OFS_SEC_SEV:    rd_mux[`PUEH_SEC_W-1:0]  = sec_sev_r;
      `PUEH_OFS_PRI_STATUS: rd_mux[0]                = cto_stat_r;
      `PUEH_OFS_PRI_CFG:    rd_mux[1:0]              = pri_cfg_r;
      `PUEH_OFS_ERR_CAP: begin
        rd_mux[`PUEH_PTR_W-1:0]       = ptr_r;
        rd_mux[`PUEH_CAP_VALID_BIT]   = ptr_valid_r;
      end
      `PUEH_OFS_HDR_LOG:    rd_mux = hdr_r;
      `PUEH_OFS_BUS_STATUS: rd_mux[`PUEH_BUS_W-1:0]  = bus_stat_r;
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

endmodule // pueh_error_handler
